// >>> rtl/sod_strap_map.vh
// Purpose: constants for the strap option decoder
// Assumes: 32-bit AXI4-Lite register bus, word aligned registers
// Notes:   offsets are byte addresses inside a 4-bit window
`ifndef SOD_STRAP_MAP_VH
`define SOD_STRAP_MAP_VH

// register byte offsets
`define SOD_ADDR_W          4
`define SOD_OFF_CONFIG      4'h0
`define SOD_OFF_STATUS      4'h4
`define SOD_OFF_CAPTURE     4'h8

// config register fields (read/write)
`define SOD_CFG_AUX_EN      0
`define SOD_CFG_ALT_AUX_EN  1
`define SOD_CFG_LOAD_DONE   2
`define SOD_CFG_W           3
`define SOD_CFG_RESET       3'h0

// status register fields (read only)
`define SOD_ST_DEV_OFF      0
`define SOD_ST_AUX_PWR      1
`define SOD_ST_JTAG         2
`define SOD_ST_LINK_DIS     3
`define SOD_ST_LINK_VALID   4
`define SOD_ST_LATCHED      5
`define SOD_ST_OPERATING    6
`define SOD_ST_PULLUP       7

// capture register fields (read only, latched strap levels)
`define SOD_CAP_DEBUG_PIN   0
`define SOD_CAP_LINK_PIN    1

// axi response codes
`define SOD_RESP_OKAY       2'h0
`define SOD_RESP_SLVERR     2'h2

// synchroniser depth and idle level of the disable pin
`define SOD_SYNC_STAGES     2
`define SOD_DISABLE_IDLE    1'b1

`endif

// >>> rtl/sod_sync.v
// Purpose: multi-bit two-flop level synchroniser
// Assumes: each bit is an independent slow level
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module sod_sync #(
    parameter WIDTH     = 1,
    parameter RESET_VAL = 1'b1
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stageOne;
            reg stageTwo;
            always @(posedge clk) begin
                if (rst) begin
                    stageOne <= RESET_VAL;
                    stageTwo <= RESET_VAL;
                end else begin
                    stageOne <= asyncIn[i];
                    stageTwo <= stageOne;
                end
            end
            assign syncOut[i] = stageTwo;
        end
    endgenerate
endmodule

// >>> rtl/sod_strap_capture.v
// Purpose: power-good edge detection and sampled strap capture
// Assumes: power good and strap pins synchronous to clk
// Notes:   captured values only change at a power-good rising edge or at load completion
`timescale 1ns/1ps
`include "sod_strap_map.vh"
module sod_strap_capture (
    input  wire clk,
    input  wire rst,
    input  wire powerGood,
    input  wire debugPin,
    input  wire linkPin,
    input  wire loadDone,
    output reg  powerGoodEvent,
    output reg  operating,
    output reg  pullupEn,
    output reg  debugLatched,
    output reg  strapsLatched,
    output reg  linkLatched,
    output reg  linkValid
);
    reg powerGoodPrev;
    reg loadDonePrev;
    wire pgRise   = powerGood & ~powerGoodPrev;
    wire loadRise = loadDone & ~loadDonePrev;

    always @(posedge clk) begin
        if (rst) begin
            powerGoodPrev  <= 1'b0;
            loadDonePrev   <= 1'b0;
            powerGoodEvent <= 1'b0;
            operating      <= 1'b0;
            pullupEn       <= 1'b1;
            debugLatched   <= 1'b1;
            strapsLatched  <= 1'b0;
            linkLatched    <= 1'b1;
            linkValid      <= 1'b0;
        end else begin
            powerGoodPrev  <= powerGood;
            loadDonePrev   <= loadDone;
            powerGoodEvent <= pgRise;
            if (pgRise) begin
                operating     <= 1'b1;
                pullupEn      <= 1'b0;
                debugLatched  <= debugPin;
                strapsLatched <= 1'b1;
                linkValid     <= 1'b0;
            end else begin
                if (!powerGood) begin
                    operating <= 1'b0;
                    // pull-up comes back while power is not good, so an open pin reads high
                    pullupEn  <= 1'b1;
                end
                // link strap sampled once per power-good cycle, then frozen
                if (loadRise && strapsLatched && !linkValid) begin
                    linkLatched <= linkPin;
                    linkValid   <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> rtl/sod_strap_decoder.v
// Purpose: decodes board strap pins into operating modes, with an AXI4-Lite register port
// Assumes: single 40 MHz clock; strap pins other than the disable pin are synchronous
// Notes:   one write and one read may be in flight at once; answers come one cycle after acceptance
`timescale 1ns/1ps
`include "sod_strap_map.vh"
// Operation
// - disable pin low forces device-off mode regardless of all other straps
// - aux power taken from soft pin three high when alt aux enable is set, else from disable pin high when aux enable is set
// - both configuration aux enable bits zero means aux power mode enabled
// - debug strap sampled at power-good event, low gives JTAG; pulled up until then
// - host link disable is active low, valid only after configuration load completes
// - host link disable comes from its own pin, soft pin one
// - disable pin is asynchronous and synchronised before mode logic uses it
// - power-good rising edge initialises operation and latches the debug strap
module sod_strap_decoder (
    input  wire        clk,
    input  wire        rst,
    input  wire        device_disable_n_pin,
    input  wire        soft_pin_three,
    input  wire        soft_pin_one,
    input  wire        power_good_in,
    input  wire        debug_port_strap,
    output reg         deviceOffMode,
    output reg         auxPowerMode,
    output reg         jtagMode,
    output reg         host_link_disable_n,
    output reg         hostLinkValid,
    output reg         power_good_event,
    output reg         deviceOperating,
    output reg         debugPullupEn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    // ------------------------------------------------------------------
    // configuration register
    reg  [`SOD_CFG_W-1:0] cfgBits;
    wire                  cfgAuxEn;
    wire                  cfgAltAuxEn;
    wire                  cfgLoadDone;

    assign cfgAuxEn    = cfgBits[`SOD_CFG_AUX_EN];
    assign cfgAltAuxEn = cfgBits[`SOD_CFG_ALT_AUX_EN];
    assign cfgLoadDone = cfgBits[`SOD_CFG_LOAD_DONE];

    // ------------------------------------------------------------------
    // disable pin synchroniser
    // the pin may move at any time; two flops keep metastability out of the mode logic
    wire disableSync;

    sod_sync #(
        .WIDTH     (1),
        .RESET_VAL (`SOD_DISABLE_IDLE)
    ) u_disable_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (device_disable_n_pin),
        .syncOut (disableSync)
    );

    // ------------------------------------------------------------------
    // power-good driven strap capture
    // the debug strap counts at the power-good edge, the link strap at load completion; later pin activity is ignored
    wire capEvent;
    wire capOperating;
    wire capPullup;
    wire capDebug;
    wire capLatched;
    wire capLink;
    wire capLinkValid;

    sod_strap_capture u_capture (
        .clk            (clk),
        .rst            (rst),
        .powerGood      (power_good_in),
        .debugPin       (debug_port_strap),
        .linkPin        (soft_pin_one),
        .loadDone       (cfgLoadDone),
        .powerGoodEvent (capEvent),
        .operating      (capOperating),
        .pullupEn       (capPullup),
        .debugLatched   (capDebug),
        .strapsLatched  (capLatched),
        .linkLatched    (capLink),
        .linkValid      (capLinkValid)
    );

    // ------------------------------------------------------------------
    // mode decode
    reg next_auxPowerMode;
    reg next_deviceOffMode;
    reg next_jtagMode;
    reg next_hostLinkDisableN;

    always @* begin
        next_deviceOffMode    = ~disableSync;
        next_jtagMode         = capLatched & ~capDebug;
        // link strap reads inactive (high) until it is valid
        next_hostLinkDisableN = 1'b1;
        if (capLinkValid) begin
            next_hostLinkDisableN = capLink;
        end
        if (!cfgAuxEn && !cfgAltAuxEn) begin
            next_auxPowerMode = 1'b1;
        end else if (cfgAltAuxEn) begin
            next_auxPowerMode = soft_pin_three;
        end else begin
            next_auxPowerMode = disableSync;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            deviceOffMode       <= 1'b0;
            auxPowerMode        <= 1'b0;
            jtagMode            <= 1'b0;
            host_link_disable_n <= 1'b1;
            hostLinkValid       <= 1'b0;
            power_good_event    <= 1'b0;
            deviceOperating     <= 1'b0;
            debugPullupEn       <= 1'b1;
        end else begin
            deviceOffMode       <= next_deviceOffMode;
            auxPowerMode        <= next_auxPowerMode;
            jtagMode            <= next_jtagMode;
            host_link_disable_n <= next_hostLinkDisableN;
            hostLinkValid       <= capLinkValid;
            power_good_event    <= capEvent;
            deviceOperating     <= capOperating;
            debugPullupEn       <= capPullup;
        end
    end

    // ------------------------------------------------------------------
    // read-back words
    wire [31:0] statusWord;
    wire [31:0] captureWord;
    wire [31:0] configWord;

    assign configWord  = {{(32-`SOD_CFG_W){1'b0}}, cfgBits};
    assign statusWord  = {24'h000000,
                          debugPullupEn,
                          deviceOperating,
                          capLatched,
                          hostLinkValid,
                          ~host_link_disable_n,
                          jtagMode,
                          auxPowerMode,
                          deviceOffMode};
    assign captureWord[31:2]               = 30'h0;
    assign captureWord[`SOD_CAP_DEBUG_PIN] = capDebug;
    assign captureWord[`SOD_CAP_LINK_PIN]  = capLink;

    // ------------------------------------------------------------------
    // axi write channel: address and data accepted in either order
    reg        awHeld;
    reg        wHeld;
    reg [3:0]  awAddr;
    reg [31:0] wData;
    reg [3:0]  wStrb;

    wire        awTake;
    wire        wTake;
    wire        haveAw;
    wire        haveW;
    wire [3:0]  curAwAddr;
    wire [31:0] curWData;
    wire [3:0]  curWStrb;
    wire        doWrite;
    wire [3:0]  wrWordAddr;
    wire        wrHitConfig;
    wire        wrHitReadOnly;

    assign awTake        = s_axi_awvalid & s_axi_awready;
    assign wTake         = s_axi_wvalid & s_axi_wready;
    assign haveAw        = awHeld | awTake;
    assign haveW         = wHeld | wTake;
    assign curAwAddr     = awTake ? s_axi_awaddr : awAddr;
    assign curWData      = wTake ? s_axi_wdata : wData;
    assign curWStrb      = wTake ? s_axi_wstrb : wStrb;
    assign doWrite       = haveAw & haveW & ~s_axi_bvalid;
    // low two address bits are ignored: every register is one aligned word
    assign wrWordAddr    = {curAwAddr[3:2], 2'b00};
    assign wrHitConfig   = (wrWordAddr == `SOD_OFF_CONFIG);
    assign wrHitReadOnly = (wrWordAddr == `SOD_OFF_STATUS) || (wrWordAddr == `SOD_OFF_CAPTURE);

    always @(posedge clk) begin
        if (rst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 4'h0;
            wData         <= 32'h00000000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SOD_RESP_OKAY;
            cfgBits       <= `SOD_CFG_RESET;
        end else begin
            if (awTake) begin
                awAddr <= s_axi_awaddr;
            end
            if (wTake) begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wrHitConfig) begin
                    s_axi_bresp <= `SOD_RESP_OKAY;
                    if (curWStrb[0]) begin
                        cfgBits <= curWData[`SOD_CFG_W-1:0];
                    end
                end else if (wrHitReadOnly) begin
                    // read-only words ignore the data but answer OKAY
                    s_axi_bresp <= `SOD_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SOD_RESP_SLVERR;
                end
            end else begin
                if (awTake) begin
                    awHeld <= 1'b1;
                end
                if (wTake) begin
                    wHeld <= 1'b1;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            // ready only while that half is not yet captured and no response waits
            s_axi_awready <= ~haveAw & ~s_axi_bvalid & ~doWrite & ~s_axi_awready;
            s_axi_wready  <= ~haveW & ~s_axi_bvalid & ~doWrite & ~s_axi_wready;
        end
    end

    // ------------------------------------------------------------------
    // axi read channel
    wire        arTake;
    wire [3:0]  rdWordAddr;
    wire        rdHitConfig;
    wire        rdHitStatus;
    wire        rdHitCapture;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;

    assign arTake       = s_axi_arvalid & s_axi_arready;
    assign rdWordAddr   = {s_axi_araddr[3:2], 2'b00};
    assign rdHitConfig  = (rdWordAddr == `SOD_OFF_CONFIG);
    assign rdHitStatus  = (rdWordAddr == `SOD_OFF_STATUS);
    assign rdHitCapture = (rdWordAddr == `SOD_OFF_CAPTURE);

    always @* begin
        if (rdHitConfig) begin
            next_rdata = configWord;
            next_rresp = `SOD_RESP_OKAY;
        end else if (rdHitStatus) begin
            next_rdata = statusWord;
            next_rresp = `SOD_RESP_OKAY;
        end else if (rdHitCapture) begin
            next_rdata = captureWord;
            next_rresp = `SOD_RESP_OKAY;
        end else begin
            next_rdata = 32'h00000000;
            next_rresp = `SOD_RESP_SLVERR;
        end
    end

    // rdata is held with rvalid, so a slow master still sees the word it asked for
    always @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SOD_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~arTake & ~s_axi_arready;
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// >>> verification/sod_board_model.sv
// Purpose: board straps and power-good source facing the decoder
// Assumes: every strap has a firm resistor level, none left floating
// Notes:   levels follow the bench request at once
`timescale 1ns/1ps
module sod_board_model (
    input  logic [4:0] boardSet,
    output logic       device_disable_n_pin,
    output logic       soft_pin_three,
    output logic       soft_pin_one,
    output logic       power_good_in,
    output logic       debug_port_strap
);
    assign device_disable_n_pin = boardSet[0];
    assign soft_pin_three       = boardSet[1];
    assign soft_pin_one         = boardSet[2];
    assign power_good_in        = boardSet[3];
    assign debug_port_strap     = boardSet[4];
endmodule

// >>> verification/sod_strap_decoder_asserts.sv
// Purpose: temporal checks on the strap option decoder ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   disable pin needs three edges through sync and output register
`timescale 1ns/1ps
module sod_strap_decoder_asserts (
    input logic clk,
    input logic rst,
    input logic device_disable_n_pin,
    input logic soft_pin_three,
    input logic power_good_in,
    input logic deviceOffMode,
    input logic auxPowerMode,
    input logic jtagMode,
    input logic host_link_disable_n,
    input logic hostLinkValid,
    input logic power_good_event,
    input logic deviceOperating,
    input logic debugPullupEn,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_rvalid,
    input logic s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_devoff; !device_disable_n_pin [*3] |=> deviceOffMode; endproperty
    a_devoff: assert property (p_devoff) else $error("device off missed");
    property p_devon; device_disable_n_pin [*3] |=> !deviceOffMode; endproperty
    a_devon: assert property (p_devon) else $error("device off stuck");
    property p_aux; (device_disable_n_pin && soft_pin_three) [*3] |=> auxPowerMode; endproperty
    a_aux: assert property (p_aux) else $error("aux mode missed");
    property p_pgevt; $rose(power_good_in) |-> ##[1:3] power_good_event; endproperty
    a_pgevt: assert property (p_pgevt) else $error("no power-good event");
    property p_pulse; power_good_event |=> !power_good_event; endproperty
    a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
    property p_init; power_good_event |-> deviceOperating && !debugPullupEn; endproperty
    a_init: assert property (p_init) else $error("event without operation");
    // a reset edge may clear the latch, so skip the edge right after it
    property p_hold; !power_good_event && !$past(rst) |-> $stable(jtagMode); endproperty
    a_hold: assert property (p_hold) else $error("latched debug mode moved");
    property p_pullup; !power_good_in [*4] |-> debugPullupEn; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up off before power good");
    property p_link; !hostLinkValid |-> host_link_disable_n; endproperty
    a_link: assert property (p_link) else $error("link disable before valid");
    property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("write answer repeated");
    property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rdrop: assert property (p_rdrop) else $error("read answer repeated");
endmodule

bind sod_strap_decoder sod_strap_decoder_asserts i_sod_strap_decoder_asserts (
    .clk, .rst, .device_disable_n_pin, .soft_pin_three, .power_good_in, .deviceOffMode, .auxPowerMode,
    .jtagMode, .host_link_disable_n, .hostLinkValid, .power_good_event, .deviceOperating, .debugPullupEn,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// >>> verification/sod_strap_decoder_tb.sv
// Purpose: self-checking bench for the strap option decoder
// Assumes: board model gives firm strap levels; one 40 MHz clock
// Notes:   boardSet bits are debug, power good, pin one, pin three, disable
`timescale 1ns/1ps
`include "sod_strap_map.vh"
module sod_strap_decoder_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  boardSet = 5'h15;
    logic        device_disable_n_pin, soft_pin_three, soft_pin_one, power_good_in, debug_port_strap;
    logic        deviceOffMode, auxPowerMode, jtagMode, host_link_disable_n, hostLinkValid;
    logic        power_good_event, deviceOperating, debugPullupEn;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          failures = 0, n_compared = 0, cycles = 0;

    always #12.5 clk = ~clk;

    sod_board_model i_sod_board_model (.boardSet, .device_disable_n_pin, .soft_pin_three, .soft_pin_one,
        .power_good_in, .debug_port_strap);
    sod_strap_decoder i_sod_strap_decoder (.clk, .rst, .device_disable_n_pin, .soft_pin_three, .soft_pin_one,
        .power_good_in, .debug_port_strap, .deviceOffMode, .auxPowerMode, .jtagMode, .host_link_disable_n,
        .hostLinkValid, .power_good_event, .deviceOperating, .debugPullupEn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // whole run needs about 125 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic waitCy(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er, "bresp");
        @(posedge clk);
    endtask

    task automatic axiRead(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed, "rdata");
        check(s_axi_rresp, er, "rresp");
        @(posedge clk);
    endtask

    task automatic testReset();
        check(jtagMode, 0, "jtag idle");
        check(host_link_disable_n, 1, "link idle");
        axiRead(`SOD_OFF_STATUS, 32'h82, `SOD_RESP_OKAY);
        axiRead(4'hC, 32'h0, `SOD_RESP_SLVERR);
        axiWrite(4'hC, 32'h7, `SOD_RESP_SLVERR);
        axiRead(`SOD_OFF_CONFIG, 32'h0, `SOD_RESP_OKAY);
    endtask

    task automatic testDevOff();
        boardSet <= 5'h16;
        waitCy(6);
        check(deviceOffMode, 1, "device off");
        boardSet <= 5'h15;
        waitCy(6);
        check(deviceOffMode, 0, "device on");
    endtask

    task automatic testAux();
        // entries: config bits, disable pin, pin three, expected aux
        logic [4:0] tab [6] = '{5'b01101, 5'b01010, 5'b10100, 5'b10111, 5'b00001, 5'b11011};
        for (int i = 0; i < 6; i++) begin
            axiWrite(`SOD_OFF_CONFIG, {30'h0, tab[i][4:3]}, `SOD_RESP_OKAY);
            boardSet <= {3'b101, tab[i][1], tab[i][2]};
            waitCy(6);
            check(auxPowerMode, tab[i][0], "aux");
        end
        boardSet <= 5'h15;
    endtask

    task automatic testPower();
        int n;
        n = 0;
        boardSet <= 5'h0D;
        do begin
            @(posedge clk);
            n++;
        end while (power_good_event !== 1'b1 && n < 10);
        check(power_good_event, 1, "event");
        @(posedge clk);
        check(power_good_event, 0, "pulse");
        check(jtagMode, 1, "jtag");
        check(deviceOperating, 1, "operating");
        check(debugPullupEn, 0, "pull-up off");
        boardSet <= 5'h1D;
        waitCy(6);
        check(jtagMode, 1, "jtag hold");
        boardSet <= 5'h15;
        waitCy(4);
        check(debugPullupEn, 1, "pull-up back");
        check(deviceOperating, 0, "operating off");
        boardSet <= 5'h1D;
        waitCy(6);
        check(jtagMode, 0, "jtag off");
    endtask

    task automatic testLink();
        boardSet <= 5'h19;
        waitCy(3);
        check(hostLinkValid, 0, "link early");
        check(host_link_disable_n, 1, "link early level");
        axiWrite(`SOD_OFF_CONFIG, 32'h4, `SOD_RESP_OKAY);
        waitCy(4);
        check(hostLinkValid, 1, "link valid");
        check(host_link_disable_n, 0, "link off");
        boardSet <= 5'h1D;
        waitCy(4);
        check(host_link_disable_n, 0, "link hold");
        axiRead(`SOD_OFF_CAPTURE, 32'h1, `SOD_RESP_OKAY);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        waitCy(4);
        testReset();
        $display("test reset done");
        testDevOff();
        $display("test device off done");
        testAux();
        $display("test aux done");
        testPower();
        $display("test power good done");
        testLink();
        $display("test host link done");
        print_verdict();
    end
endmodule
